// >>> rtl/csr_shift_rotate_unit.sv
/*
  Execution unit for the prefixed single-bit shift and rotate instructions,
  with its own byte registers, index registers, flags and program counter.
  Assumes a memory that returns read data in the clock after the read strobe
  and accepts a write in the clock of its strobe; the host port never waits.
*/
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps

// How it works
// - Rotate right through carry, old carry to bit7.
// - Shift left, old bit7 into carry.
// - Arithmetic right shift keeps bit7 sign.
// - Operand: register, pointer-pair byte, indexed byte.
// - Decode after CB; indexed DD/FD,CB,disp,op.
// - Low three opcode bits select the register.
// - Lengths 8, 15 and 23 processor clocks.
// - Sign flag mirrors result bit7, three operations.
// - Zero flag set on all-zero result.
// - Parity flag set on even ones count.
// - Half-carry and subtract flags always cleared.
// - Logical right shift always clears sign.
// - Right moves take carry from old bit0.
// - Indexed address adds signed displacement.
// - Pointer pair content addresses the operand.
module csr_shift_rotate_unit
  import csr_pkg::*;
#(
  parameter int unsigned T_DIV = CSR_T_DIV_DEF
) (
  input  wire logic          clk_i,       // System clock, 100 MHz.
  input  wire logic          rst_n_i,     // Asynchronous reset, active low.
  input  wire csr_host_req_t host_req_i,  // Host register access.
  output logic [7:0]         host_rdata_o,// Read data, cycle after the read.
  output csr_mem_req_t       mem_req_o,   // Memory address, strobes, data.
  input  wire logic [7:0]    mem_rdata_i  // Memory read data.
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_FIRST, ST_CB, ST_DISP, ST_OP, ST_MRD, ST_MWR
  } csr_state_t;

  localparam logic [7:0] DIV_LAST = 8'(T_DIV - 1);

  csr_state_t   st_r;
  csr_state_t   st_nxt;
  logic [7:0]   div_r;
  logic         tick_r;
  logic [2:0]   tcnt_r;
  logic         step_end;
  logic         rd_pend_r;
  logic [7:0]   data_r;
  logic [7:0]   op_r;
  logic [7:0]   disp_r;
  logic         indexed_r;
  logic         use_y_r;
  logic [15:0]  pc_r;
  logic [15:0]  idxx_r;
  logic [15:0]  idxy_r;
  logic [7:0]   flags_r;
  logic [7:0]   gpr_r [8];
  logic         done_r;
  logic         bad_r;
  logic [7:0]   rdata_r;
  csr_mem_req_t mem_r;

  logic         start_cmd;
  logic         busy;
  logic         issue_rd;
  logic         issue_wr;
  logic [15:0]  issue_addr;
  logic         pc_inc;
  logic         fin;
  logic         bad;
  logic         reg_we;
  logic         flag_we;
  logic         set_idx;
  logic [7:0]   cur_op;
  logic [7:0]   alu_in;
  csr_alu_t     alu_out;
  logic [7:0]   flag_val;
  logic [15:0]  ea;

  function automatic logic hit_wr(input csr_host_req_t q, input logic [3:0] a);
    return q.wr && (q.addr == a);
  endfunction

  function automatic logic grp_ok(input logic [4:0] g);
    return (g == CSR_GRP_ROT_RIGHT_CARRY) || (g == CSR_GRP_ARITH_SHL) ||
           (g == CSR_GRP_ARITH_SHR) || (g == CSR_GRP_LOGIC_SHR);
  endfunction

  function automatic logic [2:0] state_len(input csr_state_t s, input logic idx);
    case (s)
      ST_DISP: return CSR_T_DISP;
      ST_OP:   return idx ? CSR_T_IDX_OP : CSR_T_FETCH;
      ST_MRD:  return CSR_T_MEM_RD;
      ST_MWR:  return CSR_T_MEM_WR;
      default: return CSR_T_FETCH;
    endcase
  endfunction

  function automatic csr_alu_t alu(input logic [4:0] g, input logic [7:0] v, input logic cin);
    csr_alu_t o;
    o.res = v;
    o.cy  = v[0];
    case (g)
      CSR_GRP_ROT_RIGHT_CARRY: o.res = {cin, v[7:1]};
      CSR_GRP_ARITH_SHL: begin
        o.res = {v[6:0], 1'b0};
        o.cy  = v[7];
      end
      CSR_GRP_ARITH_SHR: o.res = {v[7], v[7:1]};
      default:           o.res = {1'b0, v[7:1]};
    endcase
    return o;
  endfunction

  // Bits 5 and 3 are left as they were; nothing here defines them.
  function automatic logic [7:0] flag_calc(input logic [4:0] g, input csr_alu_t a,
                                           input logic [7:0] old);
    logic [7:0] f;
    f = old;
    f[CSR_FB_S]  = (g == CSR_GRP_LOGIC_SHR) ? 1'b0 : a.res[7];
    f[CSR_FB_Z]  = (a.res == 8'h00);
    f[CSR_FB_PV] = ~^a.res;
    f[CSR_FB_H]  = 1'b0;
    f[CSR_FB_N]  = 1'b0;
    f[CSR_FB_C]  = a.cy;
    return f;
  endfunction

  assign busy      = (st_r != ST_IDLE);
  assign start_cmd = !busy && hit_wr(host_req_i, CSR_ADR_CTRL) && host_req_i.wdata[CSR_CB_START];
  assign step_end  = tick_r && (tcnt_r == (state_len(st_r, indexed_r) - 3'h1));
  assign cur_op    = (st_r == ST_OP) ? data_r : op_r;
  assign alu_in    = (st_r == ST_MRD) ? data_r : gpr_r[cur_op[2:0]];
  assign alu_out   = alu(cur_op[7:3], alu_in, flags_r[CSR_FB_C]);
  assign flag_val  = flag_calc(cur_op[7:3], alu_out, flags_r);

  // Signed displacement on the chosen index register, else the pointer pair.
  always_comb begin
    if (indexed_r) begin
      ea = (use_y_r ? idxy_r : idxx_r) + {{8{disp_r[7]}}, disp_r};
    end else begin
      ea = {gpr_r[CSR_RI_H], gpr_r[CSR_RI_L]};
    end
  end

  always_comb begin
    st_nxt     = st_r;
    issue_rd   = 1'b0;
    issue_wr   = 1'b0;
    issue_addr = pc_r;
    pc_inc     = 1'b0;
    fin        = 1'b0;
    bad        = 1'b0;
    reg_we     = 1'b0;
    flag_we    = 1'b0;
    set_idx    = 1'b0;
    if (start_cmd) begin
      st_nxt   = ST_FIRST;
      issue_rd = 1'b1;
      pc_inc   = 1'b1;
    end else if (step_end) begin
      case (st_r)
        ST_FIRST: begin
          if (data_r == CSR_PFX_CB) begin
            st_nxt   = ST_OP;
            issue_rd = 1'b1;
            pc_inc   = 1'b1;
          end else if (data_r == CSR_PFX_IDXX || data_r == CSR_PFX_IDXY) begin
            st_nxt   = ST_CB;
            issue_rd = 1'b1;
            pc_inc   = 1'b1;
            set_idx  = 1'b1;
          end else begin
            bad = 1'b1;
          end
        end
        ST_CB: begin
          if (data_r == CSR_PFX_CB) begin
            st_nxt   = ST_DISP;
            issue_rd = 1'b1;
            pc_inc   = 1'b1;
          end else begin
            bad = 1'b1;
          end
        end
        ST_DISP: begin
          st_nxt   = ST_OP;
          issue_rd = 1'b1;
          pc_inc   = 1'b1;
        end
        ST_OP: begin
          if (!grp_ok(data_r[7:3])) begin
            bad = 1'b1;
          end else if (indexed_r || data_r[2:0] == CSR_SEL_MEM) begin
            // Indexed forms always address memory, whatever the low bits say.
            st_nxt     = ST_MRD;
            issue_rd   = 1'b1;
            issue_addr = ea;
          end else begin
            reg_we  = 1'b1;
            flag_we = 1'b1;
            fin     = 1'b1;
          end
        end
        ST_MRD: begin
          st_nxt     = ST_MWR;
          issue_wr   = 1'b1;
          issue_addr = ea;
          flag_we    = 1'b1;
        end
        ST_MWR: fin = 1'b1;
        default: bad = 1'b1;
      endcase
      if (fin || bad) begin
        st_nxt = ST_IDLE;
      end
    end
  end

  // Processor clock enable; restarted on start so every instruction is aligned.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r  <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      if (start_cmd || div_r == DIV_LAST) begin
        div_r <= 8'h00;
      end else begin
        div_r <= div_r + 8'h01;
      end
      tick_r <= !start_cmd && (div_r == DIV_LAST);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r   <= ST_IDLE;
      tcnt_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      if (start_cmd || step_end) begin
        tcnt_r <= 3'h0;
      end else if (tick_r) begin
        tcnt_r <= tcnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_pend_r <= 1'b0;
      data_r    <= CSR_RST_BYTE;
      op_r      <= CSR_RST_BYTE;
      disp_r    <= CSR_RST_BYTE;
      indexed_r <= 1'b0;
      use_y_r   <= 1'b0;
    end else begin
      rd_pend_r <= mem_r.rd;
      if (rd_pend_r) begin
        data_r <= mem_rdata_i;
      end
      if (start_cmd) begin
        indexed_r <= 1'b0;
      end else if (set_idx) begin
        indexed_r <= 1'b1;
        use_y_r   <= (data_r == CSR_PFX_IDXY);
      end
      if (step_end && st_r == ST_DISP) begin
        disp_r <= data_r;
      end
      if (step_end && st_r == ST_OP) begin
        op_r <= data_r;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_r <= '0;
    end else begin
      mem_r.rd <= issue_rd;
      mem_r.wr <= issue_wr;
      if (issue_rd || issue_wr) begin
        mem_r.addr <= issue_addr;
      end
      if (issue_wr) begin
        mem_r.wdata <= alu_out.res;
      end
    end
  end

  // Host writes to the machine state are ignored while an instruction runs.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_r <= CSR_RST_WORD;
      idxx_r <= CSR_RST_WORD;
      idxy_r <= CSR_RST_WORD;
    end else if (busy) begin
      if (pc_inc) begin
        pc_r <= pc_r + 16'h0001;
      end
    end else begin
      if (hit_wr(host_req_i, CSR_ADR_PC_LO)) pc_r[7:0]  <= host_req_i.wdata;
      if (hit_wr(host_req_i, CSR_ADR_PC_HI)) pc_r[15:8] <= host_req_i.wdata;
      if (hit_wr(host_req_i, CSR_ADR_IDXX_LO)) idxx_r[7:0]  <= host_req_i.wdata;
      if (hit_wr(host_req_i, CSR_ADR_IDXX_HI)) idxx_r[15:8] <= host_req_i.wdata;
      if (hit_wr(host_req_i, CSR_ADR_IDXY_LO)) idxy_r[7:0]  <= host_req_i.wdata;
      if (hit_wr(host_req_i, CSR_ADR_IDXY_HI)) idxy_r[15:8] <= host_req_i.wdata;
      if (start_cmd) begin
        pc_r <= pc_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_r <= CSR_RST_BYTE;
    end else if (flag_we) begin
      flags_r <= flag_val;
    end else if (!busy && hit_wr(host_req_i, CSR_ADR_FLAGS)) begin
      flags_r <= host_req_i.wdata;
    end
  end

  // Operand code 6 has no register behind it and reads as zero.
  for (genvar g = 0; g < 8; g++) begin : g_gpr
    if (g == 6) begin : g_none
      assign gpr_r[g] = CSR_RST_BYTE;
    end else begin : g_reg
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          gpr_r[g] <= CSR_RST_BYTE;
        end else if (reg_we && cur_op[2:0] == 3'(g)) begin
          gpr_r[g] <= alu_out.res;
        end else if (!busy && hit_wr(host_req_i, 4'(g))) begin
          gpr_r[g] <= host_req_i.wdata;
        end
      end
    end
  end

  // A completion in the same cycle as a host clear stays visible.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_r <= 1'b0;
      bad_r  <= 1'b0;
    end else begin
      if (hit_wr(host_req_i, CSR_ADR_CTRL) && host_req_i.wdata[CSR_CB_CLEAR]) begin
        done_r <= 1'b0;
        bad_r  <= 1'b0;
      end
      if (fin || bad) begin
        done_r <= 1'b1;
      end
      if (bad) begin
        bad_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= CSR_RST_BYTE;
    end else if (host_req_i.rd) begin
      case (host_req_i.addr)
        CSR_ADR_FLAGS: rdata_r <= flags_r;
        CSR_ADR_PC_LO: rdata_r <= pc_r[7:0];
        CSR_ADR_PC_HI: rdata_r <= pc_r[15:8];
        CSR_ADR_IDXX_LO: rdata_r <= idxx_r[7:0];
        CSR_ADR_IDXX_HI: rdata_r <= idxx_r[15:8];
        CSR_ADR_IDXY_LO: rdata_r <= idxy_r[7:0];
        CSR_ADR_IDXY_HI: rdata_r <= idxy_r[15:8];
        CSR_ADR_CTRL: begin
          rdata_r               <= 8'h00;
          rdata_r[CSR_SB_BUSY]  <= busy;
          rdata_r[CSR_SB_DONE]  <= done_r;
          rdata_r[CSR_SB_BAD]   <= bad_r;
        end
        default: rdata_r <= gpr_r[host_req_i.addr[2:0]];
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign host_rdata_o = rdata_r;
  assign mem_req_o    = mem_r;

endmodule  // csr_shift_rotate_unit

// >>> pkg/csr_pkg.sv
/*
  Constants and carrier types for the prefixed shift and rotate execution unit.
  Assumes a byte-wide memory that answers a read one clock after its strobe.
*/
package csr_pkg;

  // Prefix and escape bytes of the instruction stream.
  localparam logic [7:0] CSR_PFX_CB   = 8'hcb;
  localparam logic [7:0] CSR_PFX_IDXX = 8'hdd;
  localparam logic [7:0] CSR_PFX_IDXY = 8'hfd;

  // Operation groups held in bits 7..3 of the operation byte.
  localparam logic [4:0] CSR_GRP_ROT_RIGHT_CARRY = 5'h03;
  localparam logic [4:0] CSR_GRP_ARITH_SHL       = 5'h04;
  localparam logic [4:0] CSR_GRP_ARITH_SHR       = 5'h05;
  localparam logic [4:0] CSR_GRP_LOGIC_SHR       = 5'h07;

  // Operand selector in bits 2..0; this code means the byte at the pointer pair.
  localparam logic [2:0] CSR_SEL_MEM = 3'h6;
  localparam logic [2:0] CSR_RI_H    = 3'h4;
  localparam logic [2:0] CSR_RI_L    = 3'h5;

  // Flag bit positions.
  localparam int CSR_FB_C  = 0;
  localparam int CSR_FB_N  = 1;
  localparam int CSR_FB_PV = 2;
  localparam int CSR_FB_H  = 4;
  localparam int CSR_FB_Z  = 6;
  localparam int CSR_FB_S  = 7;

  // Length in processor clocks of each machine cycle.
  localparam logic [2:0] CSR_T_FETCH  = 3'h4;
  localparam logic [2:0] CSR_T_DISP   = 3'h3;
  localparam logic [2:0] CSR_T_IDX_OP = 3'h5;
  localparam logic [2:0] CSR_T_MEM_RD = 3'h4;
  localparam logic [2:0] CSR_T_MEM_WR = 3'h3;

  // System clocks per processor clock.
  localparam int unsigned CSR_T_DIV_DEF = 4;

  // Host register offsets; 0..7 are the byte registers by operand code.
  localparam logic [3:0] CSR_ADR_FLAGS   = 4'h8;
  localparam logic [3:0] CSR_ADR_PC_LO   = 4'h9;
  localparam logic [3:0] CSR_ADR_PC_HI   = 4'ha;
  localparam logic [3:0] CSR_ADR_IDXX_LO = 4'hb;
  localparam logic [3:0] CSR_ADR_IDXX_HI = 4'hc;
  localparam logic [3:0] CSR_ADR_IDXY_LO = 4'hd;
  localparam logic [3:0] CSR_ADR_IDXY_HI = 4'he;
  localparam logic [3:0] CSR_ADR_CTRL    = 4'hf;

  // Control register bits.
  localparam int CSR_CB_START = 0;
  localparam int CSR_CB_CLEAR = 1;
  localparam int CSR_SB_BUSY  = 0;
  localparam int CSR_SB_DONE  = 1;
  localparam int CSR_SB_BAD   = 2;

  localparam logic [7:0]  CSR_RST_BYTE = 8'h00;
  localparam logic [15:0] CSR_RST_WORD = 16'h0000;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } csr_host_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } csr_mem_req_t;

  typedef struct packed {
    logic [7:0] res;
    logic       cy;
  } csr_alu_t;

endpackage

// >>> dv/csr_mem_model.sv
/*
  Byte-wide program and data memory standing at the unit's memory port.
  Assumes read data are wanted in the clock after the read strobe.
*/
`timescale 1ns/1ps
module csr_mem_model
  import csr_pkg::*;
(
  input  wire logic         clk_i,   // System clock.
  input  wire csr_mem_req_t req_i,   // Address, strobes and write data.
  output logic [7:0]        rdata_o  // Read data, one clock after the strobe.
);
  logic [7:0] mem [logic [15:0]];

  initial rdata_o = 8'h00;

  // Outside a read answer the bus wanders so a late sample cannot pass by luck.
  always @(posedge clk_i) begin
    if (req_i.rd) begin
      rdata_o <= mem.exists(req_i.addr) ? mem[req_i.addr] : 8'h00;
    end else begin
      rdata_o <= ~rdata_o;
    end
    if (req_i.wr) begin
      mem[req_i.addr] = req_i.wdata;
    end
  end
endmodule // csr_mem_model

// >>> dv/csr_shift_rotate_unit_chk.sv
/*
  Port checker for the shift and rotate unit.
  Assumes it is bound to the unit's top module and sees only its ports.
*/
`timescale 1ns/1ps
module csr_shift_rotate_unit_chk
  import csr_pkg::*;
#(
  parameter int unsigned T_DIV = CSR_T_DIV_DEF
) (
  input wire logic          clk_i,        // System clock.
  input wire logic          rst_n_i,      // Reset, active low.
  input wire csr_host_req_t host_req_i,   // Host access.
  input wire logic [7:0]    host_rdata_o, // Host read data.
  input wire csr_mem_req_t  mem_req_o,    // Memory requests.
  input wire logic [7:0]    mem_rdata_i   // Memory read data.
);
  localparam int unsigned GAP = CSR_T_MEM_RD * T_DIV;
  logic        rd_q_r;
  logic [7:0]  opnd_r;
  logic [7:0]  opc_r;
  logic [15:0] rd_adr_r;
  logic [7:0]  gap_r;
  logic        fv_r;
  logic [7:0]  exp_f_r;
  logic [4:0]  grp;
  logic [7:0]  res;

  assign grp = opc_r[7:3];
  assign res = mem_req_o.wdata;

  // The last two bytes read are the operation byte and the operand.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_q_r   <= 1'b0;
      opnd_r   <= 8'h00;
      opc_r    <= 8'h00;
      rd_adr_r <= 16'h0000;
    end else begin
      rd_q_r <= mem_req_o.rd;
      if (rd_q_r) begin
        opnd_r <= mem_rdata_i;
        opc_r  <= opnd_r;
      end
      if (mem_req_o.rd) begin
        rd_adr_r <= mem_req_o.addr;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_r <= 8'h00;
    end else begin
      gap_r <= mem_req_o.rd ? 8'h01 : ((gap_r == 8'hff) ? gap_r : gap_r + 8'h01);
    end
  end

  // Expected flags stay valid until the next fetch or host write disturbs them.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fv_r    <= 1'b0;
      exp_f_r <= 8'h00;
    end else begin
      fv_r <= mem_req_o.wr | (fv_r & ~mem_req_o.rd & ~host_req_i.wr);
      if (mem_req_o.wr) begin
        exp_f_r           <= 8'h00;
        exp_f_r[CSR_FB_S]  <= (grp != CSR_GRP_LOGIC_SHR) & res[7];
        exp_f_r[CSR_FB_Z]  <= res == 8'h00;
        exp_f_r[CSR_FB_PV] <= ~^res;
        exp_f_r[CSR_FB_C]  <= (grp == CSR_GRP_ARITH_SHL) ? opnd_r[7] : opnd_r[0];
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_wb(g);
    mem_req_o.wr && grp == g;
  endsequence
  sequence s_flag_rd;
    fv_r && host_req_i.rd && host_req_i.addr == CSR_ADR_FLAGS;
  endsequence

  rot_right_a: assert property (s_wb(CSR_GRP_ROT_RIGHT_CARRY) |-> res[6:0] == opnd_r[7:1])
    else $error("Rotate right result bits wrong.");
  arith_left_a: assert property (s_wb(CSR_GRP_ARITH_SHL) |-> res == {opnd_r[6:0], 1'b0})
    else $error("Shift left result wrong.");
  arith_right_a: assert property (s_wb(CSR_GRP_ARITH_SHR) |-> res == {opnd_r[7], opnd_r[7:1]})
    else $error("Arithmetic right result wrong.");
  logic_right_a: assert property (s_wb(CSR_GRP_LOGIC_SHR) |-> res == {1'b0, opnd_r[7:1]})
    else $error("Logical right result wrong.");
  wb_addr_a: assert property (mem_req_o.wr |-> mem_req_o.addr == rd_adr_r)
    else $error("Write back address differs from read.");
  wb_gap_a: assert property (mem_req_o.wr |-> {24'h0, gap_r} == GAP)
    else $error("Write back not one read cycle after read.");
  flag_sign_a: assert property (s_flag_rd |=> host_rdata_o[CSR_FB_S] == exp_f_r[CSR_FB_S])
    else $error("Sign flag wrong.");
  flag_zero_a: assert property (s_flag_rd |=> host_rdata_o[CSR_FB_Z] == exp_f_r[CSR_FB_Z])
    else $error("Zero flag wrong.");
  flag_par_a: assert property (s_flag_rd |=> host_rdata_o[CSR_FB_PV] == exp_f_r[CSR_FB_PV])
    else $error("Parity flag wrong.");
  flag_hn_a: assert property (s_flag_rd |=> !host_rdata_o[CSR_FB_H] && !host_rdata_o[CSR_FB_N])
    else $error("Half carry or subtract flag set.");
  flag_cy_a: assert property (s_flag_rd |=> host_rdata_o[CSR_FB_C] == exp_f_r[CSR_FB_C])
    else $error("Carry flag wrong.");
endmodule // csr_shift_rotate_unit_chk

bind csr_shift_rotate_unit csr_shift_rotate_unit_chk #(.T_DIV(T_DIV)) i_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .host_req_i(host_req_i), .host_rdata_o(host_rdata_o),
  .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i));

// >>> dv/csr_shift_rotate_unit_tb.sv
/*
  Self-checking bench for the shift and rotate unit.
  Assumes the memory model and the bound checker are compiled beside it.
*/
`timescale 1ns/1ps
module csr_shift_rotate_unit_tb
  import csr_pkg::*;
  ;
  // A short divider keeps every instruction brief while keeping the counts distinct.
  localparam int unsigned TD = 2;
  logic          clk_i;
  logic          rst_n_i = 1'b0;
  csr_host_req_t host_req_i = '0;
  logic [7:0]    host_rdata_o;
  csr_mem_req_t  mem_req_o;
  logic [7:0]    mem_rdata_i;
  int            mismatches = 0;
  int            num_checks = 0;
  logic [4:0] grps [4] = '{CSR_GRP_ROT_RIGHT_CARRY, CSR_GRP_ARITH_SHL, CSR_GRP_ARITH_SHR, CSR_GRP_LOGIC_SHR};

  csr_shift_rotate_unit #(.T_DIV(TD)) i_csr_shift_rotate_unit (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .host_req_i(host_req_i), .host_rdata_o(host_rdata_o), .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i));
  csr_mem_model u_mem (.clk_i(clk_i), .req_i(mem_req_o), .rdata_o(mem_rdata_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic hw(input logic [3:0] a, input logic [7:0] d);
    host_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
  endtask

  task automatic hr(input logic [3:0] a, output logic [7:0] d);
    host_req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    host_req_i <= '0;
    @(negedge clk_i);
    d = host_rdata_o;
    @(posedge clk_i);
  endtask

  function automatic logic [8:0] xop(input logic [4:0] g, input logic [7:0] v, input logic c);
    case (g)
      CSR_GRP_ROT_RIGHT_CARRY: xop = {v[0], c, v[7:1]};
      CSR_GRP_ARITH_SHL:       xop = {v[7], v[6:0], 1'b0};
      CSR_GRP_ARITH_SHR:       xop = {v[0], v[7], v[7:1]};
      default:                 xop = {v[0], 1'b0, v[7:1]};
    endcase
  endfunction

  function automatic logic [7:0] xfl(input logic [4:0] g, input logic [8:0] r, input logic [7:0] f0);
    xfl = f0 & 8'h28;
    xfl[CSR_FB_S] = (g != CSR_GRP_LOGIC_SHR) & r[7];
    xfl[CSR_FB_Z] = r[7:0] == 8'h00;
    xfl[CSR_FB_PV] = ~^r[7:0];
    xfl[CSR_FB_C] = r[8];
  endfunction

  // Loads the program at 0100, starts it and polls status every clock.
  task automatic run(input logic [7:0] p [4], input int ncyc, input logic [7:0] stat);
    logic [7:0] s;
    int n;
    for (int i = 0; i < 4; i++) u_mem.mem[16'(16'h0100 + i)] = p[i];
    hw(CSR_ADR_PC_LO, 8'h00);
    hw(CSR_ADR_PC_HI, 8'h01);
    hw(CSR_ADR_CTRL, 8'h03);
    // Status reads run back to back; poll n shows the state sampled n clocks after the start edge.
    host_req_i <= '{addr: CSR_ADR_CTRL, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    n = 0;
    do begin
      @(negedge clk_i);
      s = host_rdata_o;
      n++;
    end while (s[CSR_SB_BUSY] !== 1'b0 && n < 300);
    @(posedge clk_i);
    host_req_i <= '0;
    @(posedge clk_i);
    if (n >= 300) begin
      mismatches++;
      $display("CHECK FAILED %0t unit stays busy", $time);
      end_sim();
    end else begin
      chk(s, stat, "status");
      if (ncyc != 0) begin
        // The last tick falls one clock after ncyc periods; status reads idle one clock later.
        num_checks++;
        if (n != ncyc * TD + 2) begin
          mismatches++;
          $display("CHECK FAILED %0t took %0d clocks", $time, n);
        end
      end
    end
  endtask

  task automatic prep(input logic [15:0] a, input logic [7:0] v, input logic [7:0] f0);
    u_mem.mem[a] = v;
    hw(CSR_ADR_FLAGS, f0);
  endtask

  task automatic post(input logic [15:0] a, input logic [4:0] g, input logic [7:0] v, input logic [7:0] f0);
    logic [8:0] r;
    logic [7:0] d;
    r = xop(g, v, f0[0]);
    chk(u_mem.mem[a], r[7:0], "memory result");
    hr(CSR_ADR_FLAGS, d);
    chk(d, xfl(g, r, f0), "memory flags");
  endtask

  task automatic test_reg();
    logic [7:0] vals [7] = '{8'h01, 8'h80, 8'hb8, 8'h8f, 8'h00, 8'hdd, 8'h7e};
    logic [2:0] sel;
    logic [7:0] f0;
    logic [7:0] d;
    logic [8:0] r;
    for (int i = 0; i < 7; i++) begin
      sel = (i == 6) ? 3'h7 : 3'(i);
      f0 = 8'h3a | 8'(i >> 2);
      r = xop(grps[i % 4], vals[i], f0[0]);
      hw({1'b0, sel}, vals[i]);
      hw(CSR_ADR_FLAGS, f0);
      run('{CSR_PFX_CB, {grps[i % 4], sel}, 8'h00, 8'h00}, 8, 8'h02);
      hr({1'b0, sel}, d);
      chk(d, r[7:0], "register result");
      hr(CSR_ADR_FLAGS, d);
      chk(d, xfl(grps[i % 4], r, f0), "register flags");
    end
  endtask

  task automatic test_ptr();
    hw({1'b0, CSR_RI_H}, 8'h43);
    hw({1'b0, CSR_RI_L}, 8'h43);
    for (int i = 0; i < 4; i++) begin
      prep(16'h4343, 8'(8'hdd >> i), 8'h3a | 8'(i & 1));
      run('{CSR_PFX_CB, {grps[i], CSR_SEL_MEM}, 8'h00, 8'h00}, 15, 8'h02);
      post(16'h4343, grps[i], 8'(8'hdd >> i), 8'h3a | 8'(i & 1));
    end
  endtask

  task automatic test_idx();
    hw(CSR_ADR_IDXX_LO, 8'h00);
    hw(CSR_ADR_IDXX_HI, 8'h10);
    hw(CSR_ADR_IDXY_LO, 8'h05);
    hw(CSR_ADR_IDXY_HI, 8'h20);
    prep(16'h1003, 8'hb8, 8'h3a);
    run('{CSR_PFX_IDXX, CSR_PFX_CB, 8'h03, {CSR_GRP_ARITH_SHR, CSR_SEL_MEM}}, 23, 8'h02);
    post(16'h1003, CSR_GRP_ARITH_SHR, 8'hb8, 8'h3a);
    prep(16'h2003, 8'h81, 8'h3b);
    run('{CSR_PFX_IDXY, CSR_PFX_CB, 8'hfe, {CSR_GRP_LOGIC_SHR, CSR_SEL_MEM}}, 23, 8'h02);
    post(16'h2003, CSR_GRP_LOGIC_SHR, 8'h81, 8'h3b);
  endtask

  task automatic test_bad();
    run('{8'h00, 8'h00, 8'h00, 8'h00}, 0, 8'h06);
    run('{CSR_PFX_IDXX, 8'h00, 8'h00, 8'h00}, 0, 8'h06);
    run('{CSR_PFX_CB, 8'h00, 8'h00, 8'h00}, 0, 8'h06);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    test_reg();
    test_ptr();
    test_idx();
    test_bad();
    end_sim();
  end
endmodule // csr_shift_rotate_unit_tb
